// file: inc/aux_mon_cfg.svh
// constants of the auxiliary status monitor: offsets, fields, resets, timing
`ifndef AUX_MON_CFG_SVH
`define AUX_MON_CFG_SVH
`define CFG_REG_OFS    8'h00
`define STAT_REG_OFS   8'h01
`define CFG_RESET      8'h00
`define RATE_MSB       5
`define RATE_LSB       4
`define STAT_PEND_BIT  0
`define RATE_SLOW_HZ   100000
`define RATE_MID_HZ    1140000
`define RATE_FAST_HZ   8000000
`define REF_CLK_MHZ    100
`define ONESHOT_NS     20000
`define ONESHOT_CYC    ((`ONESHOT_NS * `REF_CLK_MHZ + 999) / 1000)
`define FRAME_BITS     12
`define ADDR_BITS      4
`define DATA_BITS      8
`define LAST_FRAME     4
`endif

// file: inc/aux_mon_pkg.sv
// types shared by the auxiliary status monitor
package aux_mon_pkg;
  typedef enum logic [1:0] {
    RATE_OFF  = 2'b00,
    RATE_SLOW = 2'b01,
    RATE_MID  = 2'b10,
    RATE_FAST = 2'b11
  } mon_rate_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW  = 3'b001,
    ST_HIGH = 3'b011,
    ST_LOAD = 3'b010,
    ST_GAP  = 3'b110
  } link_state_t;
endpackage

// file: logic/bit_sync.sv
// two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in and synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule

// file: logic/one_shot_hold.sv
// stretches one-cycle status events into fixed-length high pulses
`timescale 1ns/1ps
`include "aux_mon_cfg.svh"
module one_shot_hold #(
  parameter int WIDTH    = 3,
  parameter int HOLD_CYC = `ONESHOT_CYC
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // events in, stretched flags out
  input  wire logic [WIDTH-1:0] pulse,
  output logic      [WIDTH-1:0] hold
);
  logic [15:0] cnt_r   [WIDTH];
  logic [15:0] cnt_nxt [WIDTH];
  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] hold_nxt;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      cnt_nxt[i]  = cnt_r[i];
      hold_nxt[i] = hold_r[i];
      if (pulse[i]) begin
        // a new event restarts the full hold time
        cnt_nxt[i]  = 16'(HOLD_CYC);
        hold_nxt[i] = 1'b1;
      end else if (cnt_r[i] > 16'h0001) begin
        cnt_nxt[i] = cnt_r[i] - 16'h0001;
      end else begin
        cnt_nxt[i]  = 16'h0000;
        hold_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WIDTH; i++) begin
        cnt_r[i] <= 16'h0000;
      end
      hold_r <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign hold = hold_r;

  for (genvar g = 0; g < WIDTH; g++) begin : g_chk
    chk_hold_length: assert property ( // RULE_11
      @(posedge clk) disable iff (!rst_n)
      $fell(hold_r[g]) |-> ($past(cnt_r[g]) == 16'h0001 && !$past(pulse[g])))
      else $error("one-shot flag dropped before its hold time");
    chk_hold_start: assert property ( // RULE_11
      @(posedge clk) disable iff (!rst_n)
      pulse[g] |=> hold_r[g] && cnt_r[g] == 16'(HOLD_CYC))
      else $error("one-shot flag did not start on its event");
  end
endmodule

// file: logic/aux_status_monitor.sv
// auxiliary status monitor: config registers and three-wire status link
`timescale 1ns/1ps
`include "aux_mon_cfg.svh"
// What this block does
// (RULE_01) monitor rate comes from bits 5:4 of a software-written config register
// (RULE_02) rate 00 is off and reset default; 01 100 kHz, 10 1.14 MHz, 11 8 MHz
// (RULE_03) serial clock pin toggles at half the selected monitor rate
// (RULE_04) each frame is twelve bits: four address bits then eight status bits
// (RULE_05) frames repeat continuously with address stepping zero to four, then wrap
// (RULE_06) address and status byte both go out most significant bit first
// (RULE_07) load strobe rises after the last bit of every frame
// (RULE_08) capture logic samples data on clock rise, latches frame on load rise
// (RULE_09) antenna-select pin is high for diversity antenna, low for main
// (RULE_10) data, clock and load form a dedicated link apart from the main port
// (RULE_11) one-shot status flags are held high for 20 microseconds
// (RULE_12) load stays low while bits shift and is low again before next frame
module aux_status_monitor
  import aux_mon_pkg::*;
#(
  parameter int unsigned LINK_CLK_HZ = 33333333
) (
  // clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        mon_clk,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // internal status sources, frame n in bits 8n+7:8n
  input  wire logic [39:0] status_level,
  input  wire logic [2:0]  status_pulse,
  input  wire logic        tx_busy,
  input  wire logic        div_antenna,
  // auxiliary pins
  output logic             transmit_active_n,
  output logic             antenna_div,
  output logic             status_data,
  output logic             status_clock,
  output logic             status_load
);
  localparam int XW = 2 + 5 * `DATA_BITS;

  function automatic logic [15:0] rate_div(input logic [1:0] rate);
    int unsigned hz;
    int unsigned div;
    case (rate)
      RATE_SLOW: hz = `RATE_SLOW_HZ;
      RATE_MID:  hz = `RATE_MID_HZ;
      default:   hz = `RATE_FAST_HZ;
    endcase
    div = LINK_CLK_HZ / hz;
    if (div == 0) begin
      div = 1;
    end
    return 16'(div);
  endfunction

  // reset release in both domains
  logic rst_n;
  logic link_rst_n;
  bit_sync #(.WIDTH(1)) u_ref_rst (
    .clk   (ref_clk),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (rst_n)
  );
  bit_sync #(.WIDTH(1)) u_link_rst (
    .clk   (mon_clk),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  // one-shot flags of frame 1
  logic [2:0] pulse_hold;
  one_shot_hold #(.WIDTH(3), .HOLD_CYC(`ONESHOT_CYC)) u_hold (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .pulse (status_pulse),
    .hold  (pulse_hold)
  );

  // register file, ref domain
  logic [7:0]    cfg_r;
  logic [7:0]    cfg_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  logic          txn_r;
  logic          ant_r;
  logic [XW-1:0] xfer_word_r;
  logic [XW-1:0] xfer_word_nxt;
  logic          xfer_req_r;
  logic          xfer_req_nxt;
  logic [1:0]    eff_rate_r;
  logic [1:0]    eff_rate_nxt;
  logic          ack_sync;
  logic [39:0]   status_snap;

  always_comb begin
    status_snap          = status_level;
    status_snap[15:13]   = status_level[15:13] | pulse_hold; // RULE_11
    cfg_nxt              = cfg_r;
    rdata_nxt            = 8'h00;
    xfer_word_nxt        = xfer_word_r;
    xfer_req_nxt         = xfer_req_r;
    eff_rate_nxt         = eff_rate_r;
    if (reg_wr && reg_addr == `CFG_REG_OFS) begin
      cfg_nxt = reg_wdata; // RULE_01
    end
    if (reg_rd) begin
      case (reg_addr)
        `CFG_REG_OFS: begin
          rdata_nxt = cfg_r;
        end
        `STAT_REG_OFS: begin
          rdata_nxt[`RATE_MSB:`RATE_LSB] = eff_rate_r;
          // pending while a written rate has not yet reached the link; the raw
          // toggle pair would read as pending nearly all the time
          rdata_nxt[`STAT_PEND_BIT]      = (cfg_r[`RATE_MSB:`RATE_LSB] != eff_rate_r);
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
    // words only move once the far side has acknowledged the previous one,
    // so the link never samples a changing word
    if (xfer_req_r == ack_sync) begin
      eff_rate_nxt  = xfer_word_r[XW-1 -: 2];
      xfer_word_nxt = {cfg_r[`RATE_MSB:`RATE_LSB], status_snap}; // RULE_01
      xfer_req_nxt  = ~xfer_req_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r       <= `CFG_RESET; // RULE_02
      rdata_r     <= 8'h00;
      xfer_word_r <= '0;
      xfer_req_r  <= 1'b0;
      eff_rate_r  <= 2'b00;
      txn_r       <= 1'b1;
      ant_r       <= 1'b0;
    end else begin
      cfg_r       <= cfg_nxt;
      rdata_r     <= rdata_nxt;
      xfer_word_r <= xfer_word_nxt;
      xfer_req_r  <= xfer_req_nxt;
      eff_rate_r  <= eff_rate_nxt;
      txn_r       <= ~tx_busy;
      ant_r       <= div_antenna; // RULE_09
    end
  end

  assign reg_rdata         = rdata_r;
  assign transmit_active_n = txn_r;
  assign antenna_div       = ant_r;

  // crossing into the link domain
  logic          req_sync;
  logic          ack_r;
  logic [XW-1:0] snap_r;
  logic [1:0]    link_rate_r;

  bit_sync #(.WIDTH(1)) u_req_sync (
    .clk   (mon_clk),
    .rst_n (link_rst_n),
    .d     (xfer_req_r),
    .q     (req_sync)
  );
  bit_sync #(.WIDTH(1)) u_ack_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (ack_r),
    .q     (ack_sync)
  );

  always_ff @(posedge mon_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_r       <= 1'b0;
      snap_r      <= '0;
      link_rate_r <= 2'b00;
    end else if (req_sync != ack_r) begin
      ack_r       <= req_sync;
      snap_r      <= xfer_word_r;
      link_rate_r <= xfer_word_r[XW-1 -: 2];
    end
  end

  // link serialiser, mon_clk domain
  link_state_t             st_r;
  link_state_t             st_nxt;
  logic [15:0]             div_cnt_r;
  logic [15:0]             div_cnt_nxt;
  logic                    tick;
  logic [`FRAME_BITS-1:0]  shift_r;
  logic [`FRAME_BITS-1:0]  shift_nxt;
  logic [3:0]              bit_idx_r;
  logic [3:0]              bit_idx_nxt;
  logic [`ADDR_BITS-1:0]   addr_r;
  logic [`ADDR_BITS-1:0]   addr_nxt;
  logic                    sclk_r;
  logic                    sclk_nxt;
  logic                    load_r;
  logic                    load_nxt;

  function automatic logic [`FRAME_BITS-1:0] frame_word(input logic [`ADDR_BITS-1:0] a,
                                                       input logic [39:0] s);
    return {a, s[8 * a +: 8]}; // RULE_04
  endfunction

  assign tick = (div_cnt_r == 16'h0000);

  always_comb begin
    st_nxt      = st_r;
    div_cnt_nxt = tick ? rate_div(link_rate_r) - 16'h0001 : div_cnt_r - 16'h0001;
    shift_nxt   = shift_r;
    bit_idx_nxt = bit_idx_r;
    addr_nxt    = addr_r;
    sclk_nxt    = sclk_r;
    load_nxt    = load_r;
    if (link_rate_r == RATE_OFF) begin
      // no clock and no data while the monitor is switched off
      st_nxt      = ST_IDLE; // RULE_02
      div_cnt_nxt = 16'h0000;
      shift_nxt   = '0;
      bit_idx_nxt = 4'h0;
      addr_nxt    = '0;
      sclk_nxt    = 1'b0;
      load_nxt    = 1'b0;
    end else if (tick) begin
      case (st_r)
        ST_IDLE, ST_GAP: begin
          shift_nxt   = frame_word(addr_r, snap_r[39:0]);
          bit_idx_nxt = 4'h0;
          sclk_nxt    = 1'b0;
          load_nxt    = 1'b0; // RULE_12
          st_nxt      = ST_LOW;
        end
        ST_LOW: begin
          sclk_nxt = 1'b1; // RULE_03
          st_nxt   = ST_HIGH;
        end
        ST_HIGH: begin
          sclk_nxt = 1'b0; // RULE_03
          if (bit_idx_r == 4'(`FRAME_BITS - 1)) begin
            load_nxt = 1'b1; // RULE_07
            st_nxt   = ST_LOAD;
          end else begin
            shift_nxt   = {shift_r[`FRAME_BITS-2:0], 1'b0}; // RULE_06
            bit_idx_nxt = bit_idx_r + 4'h1;
            st_nxt      = ST_LOW;
          end
        end
        ST_LOAD: begin
          load_nxt = 1'b0; // RULE_12
          addr_nxt = (addr_r == `ADDR_BITS'(`LAST_FRAME)) ? '0 : addr_r + 1'b1; // RULE_05
          st_nxt   = ST_GAP;
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mon_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_r      <= ST_IDLE;
      div_cnt_r <= 16'h0000;
      shift_r   <= '0;
      bit_idx_r <= 4'h0;
      addr_r    <= '0;
      sclk_r    <= 1'b0;
      load_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      div_cnt_r <= div_cnt_nxt;
      shift_r   <= shift_nxt;
      bit_idx_r <= bit_idx_nxt;
      addr_r    <= addr_nxt;
      sclk_r    <= sclk_nxt;
      load_r    <= load_nxt;
    end
  end

  // dedicated monitor pins, separate from the main serial port
  assign status_data  = shift_r[`FRAME_BITS-1]; // RULE_10
  assign status_clock = sclk_r;                  // RULE_10
  assign status_load  = load_r;                  // RULE_10

  // checks
  logic [15:0] hi_len_r;
  logic [4:0]  rise_cnt_r;
  always_ff @(posedge mon_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hi_len_r   <= 16'h0000;
      rise_cnt_r <= 5'h00;
    end else begin
      hi_len_r   <= sclk_r ? hi_len_r + 16'h0001 : 16'h0000;
      // a frame cut short by rate off must not carry its count into the next
      if (load_r || link_rate_r == RATE_OFF) begin
        rise_cnt_r <= 5'h00;
      end else if (sclk_nxt && !sclk_r) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  chk_cfg_write: assert property ( // RULE_01
    @(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `CFG_REG_OFS) |=> cfg_r == $past(reg_wdata))
    else $error("config write not stored");
  chk_rate_off: assert property ( // RULE_02
    @(posedge mon_clk) disable iff (!link_rst_n)
    (link_rate_r == RATE_OFF) |=> (st_r == ST_IDLE && !sclk_r && !load_r))
    else $error("link active while monitor rate is off");
  chk_half_rate: assert property ( // RULE_03
    @(posedge mon_clk) disable iff (!link_rst_n)
    ($fell(sclk_r) && $stable(link_rate_r) && link_rate_r != RATE_OFF)
      |-> hi_len_r == rate_div(link_rate_r))
    else $error("serial clock high time is not one monitor period");
  chk_frame_len: assert property ( // RULE_04
    @(posedge mon_clk) disable iff (!link_rst_n)
    $rose(load_r) |-> rise_cnt_r == 5'd12)
    else $error("frame closed with wrong bit count");
  chk_addr_range: assert property ( // RULE_05
    @(posedge mon_clk) disable iff (!link_rst_n)
    (st_r == ST_LOAD && tick && link_rate_r != RATE_OFF)
      |=> addr_r == (($past(addr_r) == 4'd4) ? 4'd0 : $past(addr_r) + 4'd1))
    else $error("frame address did not step or wrap");
  chk_msb_first: assert property ( // RULE_06
    @(posedge mon_clk) disable iff (!link_rst_n)
    (st_r == ST_HIGH && tick && bit_idx_r != 4'd11 && link_rate_r != RATE_OFF)
      |=> status_data == $past(shift_r[10]))
    else $error("serial order is not msb first");
  chk_load_after: assert property ( // RULE_07
    @(posedge mon_clk) disable iff (!link_rst_n)
    $rose(load_r) |-> !sclk_r && $past(bit_idx_r) == 4'd11)
    else $error("load raised before the last bit");
  chk_load_low: assert property ( // RULE_12
    @(posedge mon_clk) disable iff (!link_rst_n)
    (st_r == ST_LOW || st_r == ST_HIGH) |-> !load_r)
    else $error("load high while bits shift");
  chk_antenna: assert property ( // RULE_09
    @(posedge ref_clk) disable iff (!rst_n)
    ##1 antenna_div == $past(div_antenna))
    else $error("antenna select does not follow the chosen antenna");

  cov_fast_frame: cover property (
    @(posedge mon_clk) disable iff (!link_rst_n)
    $rose(load_r) && link_rate_r == RATE_FAST);
  cov_addr_wrap: cover property (
    @(posedge mon_clk) disable iff (!link_rst_n)
    $rose(load_r) && addr_r == 4'd4);
  cov_rate_stop: cover property (
    @(posedge mon_clk) disable iff (!link_rst_n)
    st_r == ST_HIGH ##1 link_rate_r == RATE_OFF);
endmodule

// file: test/status_capture.sv
// far-end capture logic: shifts the status line in and latches it on load
`timescale 1ns/1ps
module status_capture (
  // three-wire status link
  input  wire logic        status_data,
  input  wire logic        status_clock,
  input  wire logic        status_load,
  // last captured frame and frame count
  output logic      [11:0] frame,
  output int               frame_cnt
);
  logic [11:0] sh_r    = 12'h000;
  logic [11:0] frame_r = 12'h000;
  int          cnt_r   = 0;

  // a plain shift register: an aborted frame only leaves stale bits behind
  always @(posedge status_clock) begin
    sh_r <= {sh_r[10:0], status_data};
  end

  always @(posedge status_load) begin
    frame_r <= sh_r;
    cnt_r   <= cnt_r + 1;
  end

  assign frame     = frame_r;
  assign frame_cnt = cnt_r;
endmodule

// file: test/test_aux_status_monitor.sv
// self-checking bench of the auxiliary status monitor
`timescale 1ns/1ps
`include "aux_mon_cfg.svh"
module test_aux_status_monitor
  import aux_mon_pkg::*;
;
  localparam int LINK_HZ = 33333333;
  logic        ref_clk, mon_clk, resetn, reg_wr, reg_rd;
  logic        rd_seen = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [39:0] status_level;
  logic [2:0]  status_pulse;
  logic        tx_busy, div_antenna, transmit_active_n, antenna_div;
  logic        status_data, status_clock, status_load;
  logic [11:0] frame;
  int          frame_cnt, error_cnt, checked, seed, n;
  logic [7:0]  rd_q[$];
  logic [11:0] fr_q[$];

  aux_status_monitor #(.LINK_CLK_HZ(LINK_HZ)) u_dut (
    .ref_clk           (ref_clk),
    .resetn            (resetn),
    .mon_clk           (mon_clk),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .status_level      (status_level),
    .status_pulse      (status_pulse),
    .tx_busy           (tx_busy),
    .div_antenna       (div_antenna),
    .transmit_active_n (transmit_active_n),
    .antenna_div       (antenna_div),
    .status_data       (status_data),
    .status_clock      (status_clock),
    .status_load       (status_load)
  );

  status_capture u_cap (
    .status_data  (status_data),
    .status_clock (status_clock),
    .status_load  (status_load),
    .frame        (frame),
    .frame_cnt    (frame_cnt)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // link clock offset so its edges never line up with the register clock
  initial begin
    mon_clk = 1'b0;
    #7;
    forever #15 mon_clk = ~mon_clk;
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_val(32'(got), 32'(exp));
  endtask

  task automatic cmp_frame(input logic [11:0] got, input logic [11:0] exp);
    cmp_val(32'(got), 32'(exp));
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one bus cycle; strobes stay as set until the next call
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge ref_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    if (r) rd_q.push_back(e);
  endtask

  function automatic logic [11:0] exp_frame(input int a);
    return {4'(a), status_level[8*a +: 8]};
  endfunction

  task automatic wait_addr(input logic [3:0] a);
    for (int i = 0; i < 12; i++) begin
      @(frame_cnt);
      #1;
      if (frame[11:8] === a) break;
    end
  endtask

  task automatic run_rate(input mon_rate_t rt, input int nfr, input int lim);
    logic [7:0] cfg;
    int         tick;
    realtime    t0;
    cfg = {2'($random(seed)), rt, 4'($random(seed))};
    tick = LINK_HZ / (rt == RATE_FAST ? `RATE_FAST_HZ :
                      rt == RATE_MID ? `RATE_MID_HZ : `RATE_SLOW_HZ);
    status_level <= {$random(seed), 8'($random(seed))};
    bus(1'b1, 1'b0, `CFG_REG_OFS, cfg, 8'h00);
    bus(1'b0, 1'b1, `CFG_REG_OFS, 8'h00, cfg);
    bus(1'b0, 1'b1, `STAT_REG_OFS, 8'h00, 8'h01);
    bus(1'b0, 1'b0, `CFG_REG_OFS, 8'h00, 8'h00);
    for (int i = 0; i < nfr; i++) fr_q.push_back(exp_frame(i % 5));
    @(posedge status_clock);
    t0 = $realtime;
    @(posedge status_clock);
    cmp_val(32'(int'(($realtime - t0) / 30.0)), 32'(2 * tick));
    bus(1'b1, 1'b0, `STAT_REG_OFS, 8'hFF, 8'h00);
    bus(1'b0, 1'b1, `STAT_REG_OFS, 8'h00, {2'b00, rt, 4'h0});
    bus(1'b0, 1'b0, `CFG_REG_OFS, 8'h00, 8'h00);
    for (int i = 0; i < lim && fr_q.size() != 0; i++) @(posedge ref_clk);
    cmp_val(32'(fr_q.size()), 32'h0000_0000);
    bus(1'b1, 1'b0, `CFG_REG_OFS, 8'h00, 8'h00);
    bus(1'b0, 1'b0, `CFG_REG_OFS, 8'h00, 8'h00);
    repeat (60) @(posedge mon_clk);
    cmp_val(32'({status_data, status_clock, status_load}), 32'h0000_0000);
    n = frame_cnt;
    repeat (300) @(posedge ref_clk);
    cmp_val(32'(frame_cnt), 32'(n));
  endtask

  always @(posedge ref_clk) begin
    if (rd_seen) cmp_reg(reg_rdata, rd_q.pop_front());
    else if (resetn) cmp_reg(reg_rdata, 8'h00);
    rd_seen <= reg_rd;
  end

  always @(frame_cnt) begin
    #1;
    if (fr_q.size() != 0) cmp_frame(frame, fr_q.pop_front());
  end

  // full run is near 380 us; this only cuts a hang short
  initial begin
    #800_000;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    seed = 49;
    error_cnt = 0;
    checked = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    status_level = 40'h00_0000_0000;
    status_pulse = 3'b000;
    tx_busy = 1'b0;
    div_antenna = 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp_val(32'({transmit_active_n, antenna_div, status_data, status_clock, status_load}),
            32'h0000_0010);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, 1'b1, `CFG_REG_OFS, 8'h00, `CFG_RESET);
    bus(1'b1, 1'b0, 8'h07, 8'hA5, 8'h00);
    bus(1'b0, 1'b1, 8'h07, 8'h00, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      tx_busy     <= 1'($random(seed));
      div_antenna <= 1'($random(seed));
      repeat (2) @(posedge ref_clk);
      cmp_val(32'(antenna_div), 32'(div_antenna));
      cmp_val(32'(transmit_active_n), 32'(1'(~tx_busy)));
    end
    run_rate(RATE_FAST, 6, 3000);
    run_rate(RATE_MID, 2, 6000);
    run_rate(RATE_SLOW, 1, 30000);
    // one-shot flags must outlive the level bits, which are held low here
    status_level[15:13] <= 3'b000;
    bus(1'b1, 1'b0, `CFG_REG_OFS, 8'h30, 8'h00);
    bus(1'b0, 1'b0, `CFG_REG_OFS, 8'h00, 8'h00);
    wait_addr(4'h3);
    @(posedge ref_clk);
    status_pulse <= 3'b111;
    @(posedge ref_clk);
    status_pulse <= 3'b000;
    wait_addr(4'h0);
    wait_addr(4'h1);
    cmp_val(32'(frame), 32'({4'h1, 3'b111, status_level[12:8]}));
    repeat (`ONESHOT_CYC + 100) @(posedge ref_clk);
    wait_addr(4'h0);
    wait_addr(4'h1);
    cmp_val(32'(frame), 32'({4'h1, 3'b000, status_level[12:8]}));
    tally_and_finish;
  end
endmodule
